// ===== pkg/selftest_pkg.sv
// Purpose: Shared constants for the self-test indicator lamps.
// Assumes: 125 MHz system clock; lamp n sits at bit n-1 of a vector.
// Notes: Phase times are kept in ms and turned into cycle counts here.
// How it works
// - Power-up or preset lights all sixteen board lamps and both front lamps.
// - Front lamp one clears once tests 0-6, 10 and 11 have passed.
// - Front lamp two clears once tests 9, 12 and 13 have passed.
// - With no failure both front lamps are dark as soon as both test groups have passed.
// - With no failure all board lamps clear once the self-test is done and one second has passed since trigger.
// - Failure phase one: lamps 15,16 dark, lamp n+1 flags failed test n.
// - Failure phase two: lamp 16 lit, 9-15 dark, 1-8 show failed address line.
// - After phase two all sixteen lamps show failed data bus lines.
package selftest_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SETTLE_MS = 1000;   // Pass indication time
  localparam int unsigned PHASE_MS = 2000;    // Each failure display phase
  localparam int unsigned SETTLE_CYCLES = CYC_PER_MS * SETTLE_MS;
  localparam int unsigned PHASE_CYCLES = CYC_PER_MS * PHASE_MS;
  localparam int unsigned TMR_W = 28;         // Holds PHASE_CYCLES

  // ----------------------------------------------------------------
  // Lamp layout
  // ----------------------------------------------------------------
  localparam int unsigned LAMP_COUNT = 16;
  localparam int unsigned TEST_COUNT = 14;
  localparam int unsigned ADDR_LINES = 8;
  localparam logic [15:0] LAMPS_ALL_ON = 16'hFFFF;
  localparam logic [15:0] LAMPS_ALL_OFF = 16'h0000;
  localparam logic [1:0] FRONT_ALL_ON = 2'h3;
  localparam logic [13:0] FRONT1_TESTS = 14'h0C7F;  // Tests 0-6, 10, 11
  localparam logic [13:0] FRONT2_TESTS = 14'h3200;  // Tests 9, 12, 13

  typedef enum logic [2:0] {
    ALL_ON,
    PASSED,
    SHOW_TEST,
    SHOW_ADDR,
    SHOW_DATA
  } lamp_state_e;

endpackage

// ===== pkg/phase_tmr_if.sv
// Purpose: Carries start, load value and expiry between sequencer and timer.
// Assumes: Single clock domain.
// Notes: A start reloads the timer even while it is still counting.
`timescale 1ns/1ps
interface phase_tmr_if;
  import selftest_pkg::*;
  logic start;
  logic [TMR_W-1:0] limit;
  logic expired;

  modport timer (input start, input limit, output expired);
  modport user (output start, output limit, input expired);
endinterface

// ===== core/phase_timer.sv
// Purpose: Down-counter that flags the end of a timed display phase.
// Assumes: limit is at least 2.
// Notes: expired pulses exactly limit cycles after the start cycle.
`timescale 1ns/1ps
module phase_timer
  import selftest_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencer side
  phase_tmr_if.timer tmr
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  wire logic running = (cnt_q != '0);

  // ------------------------------------------------------------
  // Count down
  // ------------------------------------------------------------
  // Reload wins over counting so a new phase always gets a full span
  assign cnt_d = tmr.start ? tmr.limit :
                 running ? cnt_q - TMR_W'(1) : cnt_q;
  // Not gated by start: the sequencer feeds expiry back into start
  assign tmr.expired = (cnt_q == TMR_W'(1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ===== core/self_test_indicator.sv
// Purpose: Drives front check lamps and board lamps from self-test results.
// Assumes: Test results arrive as one-cycle reports; inputs are synchronous.
// Notes: Only the first failing report is displayed until the next trigger.
`timescale 1ns/1ps
module self_test_indicator
  import selftest_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SETTLE_CYCLES,
  parameter int unsigned PHASE_CYC = PHASE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operator key
  input wire logic preset_key,
  // Test result reports
  input wire logic result_valid,
  input wire logic [3:0] result_num,
  input wire logic result_pass,
  input wire logic self_test_done,
  // Failed line vectors
  input wire logic [7:0] io_addr_fail,
  input wire logic [15:0] io_data_fail,
  // Lamps, bit n drives lamp n+1
  output logic [15:0] board_lamp,
  output logic [1:0] front_check_lamp
);

  // ----------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------
  logic por_q;
  logic key_q;
  logic trigger;

  // Power-on acts as a trigger in the first cycle after reset release
  assign trigger = por_q || (preset_key && !key_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_q <= 1'b1;
      key_q <= 1'b0;
    end else begin
      por_q <= 1'b0;
      key_q <= preset_key;
    end
  end

  // ----------------------------------------------------------------
  // Phase timer
  // ----------------------------------------------------------------
  phase_tmr_if tmr_bus ();

  phase_timer u_timer (
    .clk(clk),
    .rst(rst),
    .tmr(tmr_bus.timer)
  );

  // ----------------------------------------------------------------
  // Result bookkeeping
  // ----------------------------------------------------------------
  lamp_state_e state_q;
  lamp_state_e state_d;
  logic [13:0] pass_q;
  logic [13:0] pass_d;
  logic [3:0] fail_num_q;
  logic sec_done_q;
  logic done_q;
  logic [15:0] lamp_q;
  logic [15:0] lamp_d;
  logic [1:0] front_q;
  logic [1:0] front_d;

  wire logic num_ok = (result_num < 4'(TEST_COUNT));
  wire logic pass_evt = result_valid && result_pass && num_ok;
  wire logic fail_evt = result_valid && !result_pass && state_q == ALL_ON;
  wire logic [13:0] pass_bit = 14'(1) << result_num;
  wire logic front1_ok = ((pass_q & FRONT1_TESTS) == FRONT1_TESTS);
  wire logic front2_ok = ((pass_q & FRONT2_TESTS) == FRONT2_TESTS);
  // Next failure number, so the first test phase pattern is right at once
  wire logic [3:0] fail_num_d = (fail_evt && !trigger) ? result_num : fail_num_q;
  wire logic [15:0] test_onehot = 16'(16'h0001 << fail_num_d);

  // A trigger forgets all earlier passes
  assign pass_d = trigger ? '0 : (pass_pass_or(pass_q, pass_bit, pass_evt));

  function automatic logic [13:0] pass_pass_or(input logic [13:0] cur,
                                               input logic [13:0] bit_v,
                                               input logic en);
    pass_pass_or = en ? (cur | bit_v) : cur;
  endfunction

  // Front lamps clear only on their own groups of passes
  assign front_d[0] = trigger ? 1'b1 : !front1_ok;
  assign front_d[1] = trigger ? 1'b1 : !front2_ok;

  // ----------------------------------------------------------------
  // Display sequencer
  // ----------------------------------------------------------------
  // Timer loads the settle time at trigger, a phase span on entering SHOW_TEST and SHOW_ADDR
  assign tmr_bus.start = trigger || fail_evt ||
                         (tmr_bus.expired && state_q == SHOW_TEST);
  assign tmr_bus.limit = trigger ? TMR_W'(SETTLE_CYC) : TMR_W'(PHASE_CYC);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ALL_ON: begin
        if (fail_evt) begin
          state_d = SHOW_TEST;
        end else if (sec_done_q && done_q) begin
          state_d = PASSED;
        end
      end
      PASSED: state_d = PASSED;
      SHOW_TEST: begin
        if (tmr_bus.expired) begin
          state_d = SHOW_ADDR;
        end
      end
      SHOW_ADDR: begin
        if (tmr_bus.expired) begin
          state_d = SHOW_DATA;
        end
      end
      SHOW_DATA: state_d = SHOW_DATA;
    endcase
    if (trigger) begin
      state_d = ALL_ON;
    end
  end

  // Board lamp pattern per state
  always_comb begin
    lamp_d = LAMPS_ALL_ON;
    unique case (state_d)
      ALL_ON: lamp_d = LAMPS_ALL_ON;
      PASSED: lamp_d = LAMPS_ALL_OFF;
      SHOW_TEST: lamp_d = {2'b00, test_onehot[13:0]};
      SHOW_ADDR: lamp_d = {1'b1, 7'h00, io_addr_fail};
      SHOW_DATA: lamp_d = io_data_fail;
    endcase
  end

  // Failure number is captured on the edge that enters the state that displays it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ALL_ON;
      pass_q <= '0;
      fail_num_q <= 4'h0;
      lamp_q <= LAMPS_ALL_ON;
      front_q <= FRONT_ALL_ON;
    end else begin
      state_q <= state_d;
      pass_q <= pass_d;
      lamp_q <= lamp_d;
      front_q <= front_d;
      fail_num_q <= fail_num_d;
    end
  end

  // Settle time and test completion flags, cleared by each trigger
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_done_q <= 1'b0;
      done_q <= 1'b0;
    end else if (trigger) begin
      sec_done_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      sec_done_q <= sec_done_q || (tmr_bus.expired && state_q == ALL_ON);
      done_q <= done_q || self_test_done;
    end
  end

  // Outputs come straight from flops
  assign board_lamp = lamp_q;
  assign front_check_lamp = front_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_trigger_lights_all: assert property (
    trigger |=> board_lamp == LAMPS_ALL_ON && front_check_lamp == FRONT_ALL_ON)
    else $error("lamps not all lit after trigger");

  a_front_one_group: assert property (
    !trigger && !front1_ok |=> front_check_lamp[0])
    else $error("front lamp one cleared early");

  a_front_two_group: assert property (
    !trigger && !front2_ok |=> front_check_lamp[1])
    else $error("front lamp two cleared early");

  a_front_dark_pass: assert property (
    state_q == PASSED && front1_ok && front2_ok && !trigger |=> front_check_lamp == 2'b00)
    else $error("front lamps lit after full pass");

  a_pass_lamps_off: assert property (
    state_q == ALL_ON && !trigger && !fail_evt && sec_done_q && done_q
      |=> board_lamp == LAMPS_ALL_OFF)
    else $error("board lamps not cleared on pass");

  a_test_phase_show: assert property (
    fail_evt && !trigger |=> board_lamp == (16'h0001 << $past(result_num)))
    else $error("wrong failed test pattern");

  a_addr_phase_show: assert property (
    state_q == SHOW_ADDR |-> board_lamp[15:8] == 8'h80)
    else $error("address phase upper lamps wrong");

  a_data_phase_show: assert property (
    state_q == SHOW_DATA && !trigger |=> board_lamp == $past(io_data_fail))
    else $error("data phase lamps wrong");

  a_phase_advance: assert property (
    $rose(state_q == SHOW_TEST) && !trigger ##1 !trigger [*3]
      |-> state_q == SHOW_TEST)
    else $error("test phase ended too soon");

  c_full_pass: cover property (state_q == ALL_ON ##1 state_q == PASSED);
  c_test_to_addr: cover property (state_q == SHOW_TEST ##1 state_q == SHOW_ADDR);
  c_addr_to_data: cover property (state_q == SHOW_ADDR ##1 state_q == SHOW_DATA);
  c_preset_again: cover property (state_q == SHOW_DATA && trigger);

endmodule

// ===== bench/lamp_viewer.sv
// Purpose: Technician view of the lamps; flags every visible pattern change.
// Assumes: Lamps are registered on the rising clk edge.
// Notes: Passive; a steady pattern produces no report.
`timescale 1ns/1ps
module lamp_viewer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Lamps on the board and front panel
  input wire logic [15:0] board_lamp,
  input wire logic [1:0] front_check_lamp,
  // Change report
  output logic seen,
  output logic [17:0] view
);
  logic [17:0] last_q;

  // Case inequality so an unknown lamp also counts as a change
  assign view = {front_check_lamp, board_lamp};
  assign seen = (view !== last_q);

  // Remember what the eye last saw; all lit while held in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 18'h3FFFF;
    end else begin
      last_q <= view;
    end
  end
endmodule

// ===== bench/self_test_result_indicator_test.sv
// Purpose: Self-checking bench for the self-test lamp sequencer.
// Assumes: Short settle and phase counts; lamp changes are seen by a viewer.
// Notes: Expected patterns are queued by the driver and popped on each change.
`timescale 1ns/1ps
module self_test_result_indicator_test;
  import selftest_pkg::*;
  localparam int SC = 20;
  localparam int PC = 30;
  typedef struct {logic [17:0] v; int cyc;} note_s;
  logic clk = 1'b0, rst = 1'b1, preset_key = 1'b0;
  logic result_valid = 1'b0, result_pass = 1'b0, self_test_done = 1'b0;
  logic [3:0] result_num = 4'h0;
  logic [7:0] io_addr_fail = 8'h00;
  logic [15:0] io_data_fail = 16'h0000;
  logic [15:0] board_lamp;
  logic [1:0] front_check_lamp;
  logic seen;
  logic [17:0] view;
  logic [31:0] seed = 32'h00002F58;
  logic [31:0] r;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  int pl[12] = '{0, 1, 2, 3, 4, 5, 6, 10, 11, 9, 12, 13};
  note_s notes[$];
  note_s n;

  self_test_indicator #(.SETTLE_CYC(SC), .PHASE_CYC(PC)) uut (.clk(clk), .rst(rst),
    .preset_key(preset_key), .result_valid(result_valid), .result_num(result_num),
    .result_pass(result_pass), .self_test_done(self_test_done),
    .io_addr_fail(io_addr_fail), .io_data_fail(io_data_fail),
    .board_lamp(board_lamp), .front_check_lamp(front_check_lamp));
  lamp_viewer viewer (.clk(clk), .rst(rst), .board_lamp(board_lamp),
    .front_check_lamp(front_check_lamp), .seen(seen), .view(view));

  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cycle count doubles as the hang limit; a full run is about 1050 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      close_out();
    end
  end

  // Every visible change must match the oldest queued pattern
  always @(negedge clk) begin
    if (!rst && seen) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("wrong value at %0t: unexpected lamps %h", $time, view);
      end else begin
        n = notes.pop_front();
        check(32'(view), 32'(n.v));
        if (n.cyc >= 0) check(32'(cyc), 32'(n.cyc));
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(32'(view), 32'h3FFFF);
    // Group one passes first, so lamp one must drop before lamp two
    notes.push_back('{18'h2FFFF, -1});
    notes.push_back('{18'h0FFFF, -1});
    notes.push_back('{18'h00000, -1});
    foreach (pl[i]) begin
      @(negedge clk);
      result_valid = 1'b1;
      result_num = 4'(pl[i]);
      result_pass = 1'b1;
    end
    @(negedge clk);
    result_valid = 1'b0;
    self_test_done = 1'b1;
    @(negedge clk);
    self_test_done = 1'b0;
    repeat (SC + 5) @(negedge clk);
    check(32'(notes.size()), 32'h0);
    check(32'(view), 32'h0);
    // Every test number fails once after a preset
    for (int t = 0; t < TEST_COUNT; t++) begin
      @(negedge clk);
      preset_key = 1'b1;
      notes.push_back('{18'h3FFFF, -1});
      @(negedge clk);
      preset_key = 1'b0;
      r = rnd();
      io_addr_fail = r[7:0];
      io_data_fail = {1'b0, r[22:8]};
      @(negedge clk);
      result_valid = 1'b1;
      result_num = 4'(t);
      result_pass = 1'b0;
      notes.push_back('{{2'h3, 16'(1 << t)}, cyc + 1});
      notes.push_back('{{2'h3, 1'b1, 7'h00, io_addr_fail}, cyc + 1 + PC});
      notes.push_back('{{2'h3, io_data_fail}, cyc + 1 + 2 * PC});
      @(negedge clk);
      result_valid = 1'b0;
      repeat (2 * PC + 4) @(negedge clk);
      io_data_fail = io_data_fail ^ 16'h0101;
      notes.push_back('{{2'h3, io_data_fail}, -1});
      repeat (3) @(negedge clk);
    end
    check(32'(notes.size()), 32'h0);
    close_out();
  end
endmodule
